//--- include/fcm_pkg.sv
// Functional notes
// - each port instance owns an independent transmit-rate control function.
// - credit grows at a constant rate from committed rate, saturating at maximum.
// - idle ports keep accruing credit; each frame spends its whole length in credit as its first byte leaves.
// - with credit on hand, data flows as offered, capped by peak rate.
// - once credit runs out, forwarding is held to the committed rate.
// - long-term forwarded rate never exceeds the committed rate.
// - congestion is signalled by two header bits, forward and backward.
// - source congestion sets the forward bit on frames sent into the network.
// - source congestion also sets the backward bit on frames toward the user.
// - sink congestion sets the forward bit on frames delivered to the user.
// - sink congestion sets the backward bit on frames sent into the network.
package fcm_pkg;
   localparam int FCM_DATA_W = 8;
   localparam int FCM_LEN_W = 13;
   localparam int FCM_FIFO_DEPTH = 16;
   localparam int FCM_LVL_W = $clog2(FCM_FIFO_DEPTH) + 1;
   localparam int FCM_CRED_INT_W = 16;
   localparam int FCM_CRED_FRAC = 8;
   localparam int FCM_CRED_W = FCM_CRED_INT_W + FCM_CRED_FRAC;
   localparam int FCM_PIR_W = 8;
   localparam logic [FCM_CRED_W-1:0] FCM_CRED_RST = 24'h000000;
   localparam logic [FCM_PIR_W-1:0] FCM_PIR_RST = 8'h00;

   // one byte of a frame with its sideband; len/fecn/becn valid on first
   typedef struct packed {
      logic first;
      logic last;
      logic fecn;
      logic becn;
      logic [FCM_LEN_W-1:0] len;
      logic [FCM_DATA_W-1:0] data;
   } fcm_word_t;

   localparam int FCM_WORD_W = $bits(fcm_word_t);
   localparam fcm_word_t FCM_WORD_RST = '0;
endpackage

//--- core/fcm_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module fcm_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   // refused at elaboration: pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
      $error("fcm_fifo: depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = (cnt_reg != DEPTH[AW:0]);
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign level = cnt_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- core/fcm_port.sv
`timescale 1ns/10ps
`default_nettype none
// one instance per port; nothing is shared between instances
module fcm_port
   import fcm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   // user -> network
   input wire logic usr_rx_valid,
   input wire fcm_word_t usr_rx_word,
   output logic usr_rx_ready,
   output logic net_tx_valid,
   output fcm_word_t net_tx_word,
   input wire logic net_tx_ready,
   // network -> user
   input wire logic net_rx_valid,
   input wire fcm_word_t net_rx_word,
   output logic net_rx_ready,
   output logic usr_tx_valid,
   output fcm_word_t usr_tx_word,
   input wire logic usr_tx_ready,
   // configuration
   input wire logic [FCM_CRED_W-1:0] cir_inc,
   input wire logic [FCM_CRED_INT_W-1:0] credit_max,
   input wire logic [FCM_PIR_W-1:0] pir_gap,
   input wire logic [FCM_LVL_W-1:0] ing_thresh,
   input wire logic [FCM_LVL_W-1:0] eg_thresh,
   // status
   output logic ing_cong,
   output logic eg_cong,
   output logic [FCM_CRED_INT_W-1:0] credit_bytes
);
   fcm_word_t ing_head;
   fcm_word_t eg_head;
   logic ing_valid;
   logic eg_valid;
   logic ing_pop;
   logic eg_pop;
   logic ing_rdy_int;
   logic [FCM_LVL_W-1:0] ing_level;
   logic [FCM_LVL_W-1:0] eg_level;

   fcm_fifo #(.WIDTH(FCM_WORD_W), .DEPTH(FCM_FIFO_DEPTH)) u_ing_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(usr_rx_valid),
      .in_data(usr_rx_word),
      .in_ready(ing_rdy_int),
      .out_valid(ing_valid),
      .out_data(ing_head),
      .out_ready(ing_pop),
      .level(ing_level)
   );

   fcm_fifo #(.WIDTH(FCM_WORD_W), .DEPTH(FCM_FIFO_DEPTH)) u_eg_fifo (
      .mclk(mclk),
      .rst(rst),
      .in_valid(net_rx_valid),
      .in_data(net_rx_word),
      .in_ready(net_rx_ready),
      .out_valid(eg_valid),
      .out_data(eg_head),
      .out_ready(eg_pop),
      .level(eg_level)
   );

   assign usr_rx_ready = ing_rdy_int;

   // congestion flags, registered so marking uses a stable view
   logic ing_cong_reg;
   logic eg_cong_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ing_cong_reg <= 1'b0;
         eg_cong_reg <= 1'b0;
      end else begin
         ing_cong_reg <= (ing_level >= ing_thresh);
         eg_cong_reg <= (eg_level >= eg_thresh);
      end
   end

   assign ing_cong = ing_cong_reg;
   assign eg_cong = eg_cong_reg;

   // credit bucket in fixed point bytes
   logic [FCM_CRED_W-1:0] credit_reg;
   logic [FCM_CRED_W-1:0] credit_next;
   logic [FCM_CRED_W:0] cred_sum;
   logic [FCM_CRED_W-1:0] cred_cap;
   logic [FCM_CRED_W-1:0] frame_cost;
   logic credit_ok;
   logic spend;

   assign cred_cap = {credit_max, {FCM_CRED_FRAC{1'b0}}};
   assign frame_cost = {{(FCM_CRED_INT_W - FCM_LEN_W){1'b0}}, ing_head.len,
      {FCM_CRED_FRAC{1'b0}}};
   // whole frame must be covered before its first byte leaves
   assign credit_ok = (credit_reg >= frame_cost);
   assign spend = ing_pop && ing_head.first;

   always_comb begin
      // spend only happens when balance covers cost, so no underflow
      cred_sum = {1'b0, credit_reg} + {1'b0, cir_inc};
      if (spend) begin
         cred_sum = cred_sum - {1'b0, frame_cost};
      end
      if (cred_sum > {1'b0, cred_cap}) begin
         credit_next = cred_cap;
      end else begin
         credit_next = cred_sum[FCM_CRED_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         credit_reg <= FCM_CRED_RST;
      end else begin
         credit_reg <= credit_next;
      end
   end

   // status view of the whole-byte balance
   logic [FCM_CRED_INT_W-1:0] credit_bytes_reg;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         credit_bytes_reg <= '0;
      end else begin
         credit_bytes_reg <= credit_next[FCM_CRED_W-1:FCM_CRED_FRAC];
      end
   end

   assign credit_bytes = credit_bytes_reg;

   // peak-rate spacing: one byte per pir_gap+1 cycles at most
   logic [FCM_PIR_W-1:0] pir_cnt_reg;
   logic pir_ok;

   assign pir_ok = (pir_cnt_reg == '0);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pir_cnt_reg <= FCM_PIR_RST;
      end else if (ing_pop) begin
         pir_cnt_reg <= pir_gap;
      end else if (!pir_ok) begin
         pir_cnt_reg <= pir_cnt_reg - 1'b1;
      end
   end

   // toward network: gated by peak spacing and, at frame start, by credit
   logic net_tx_valid_reg;
   fcm_word_t net_tx_word_reg;

   // mid-frame bytes are not gated by credit: the cost was paid up front
   assign ing_pop = ing_valid && (!net_tx_valid_reg || net_tx_ready) &&
      pir_ok && (!ing_head.first || credit_ok);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         net_tx_valid_reg <= 1'b0;
         net_tx_word_reg <= FCM_WORD_RST;
      end else if (ing_pop) begin
         net_tx_valid_reg <= 1'b1;
         net_tx_word_reg <= ing_head;
         if (ing_head.first) begin
            net_tx_word_reg.fecn <= ing_head.fecn | ing_cong_reg;
            net_tx_word_reg.becn <= ing_head.becn | eg_cong_reg;
         end
      end else if (net_tx_ready) begin
         net_tx_valid_reg <= 1'b0;
      end
   end

   assign net_tx_valid = net_tx_valid_reg;
   assign net_tx_word = net_tx_word_reg;

   // toward user: no rate control, only marking
   logic usr_tx_valid_reg;
   fcm_word_t usr_tx_word_reg;

   assign eg_pop = eg_valid && (!usr_tx_valid_reg || usr_tx_ready);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         usr_tx_valid_reg <= 1'b0;
         usr_tx_word_reg <= FCM_WORD_RST;
      end else if (eg_pop) begin
         usr_tx_valid_reg <= 1'b1;
         usr_tx_word_reg <= eg_head;
         if (eg_head.first) begin
            usr_tx_word_reg.fecn <= eg_head.fecn | eg_cong_reg;
            usr_tx_word_reg.becn <= eg_head.becn | ing_cong_reg;
         end
      end else if (usr_tx_ready) begin
         usr_tx_valid_reg <= 1'b0;
      end
   end

   assign usr_tx_valid = usr_tx_valid_reg;
   assign usr_tx_word = usr_tx_word_reg;
endmodule
`default_nettype wire

//--- tb/fcm_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module fcm_port_props
   import fcm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic net_tx_valid,
   input wire fcm_word_t net_tx_word,
   input wire logic net_tx_ready,
   input wire logic usr_tx_valid,
   input wire fcm_word_t usr_tx_word,
   input wire logic usr_tx_ready,
   input wire logic [FCM_CRED_INT_W-1:0] credit_max,
   input wire logic [FCM_PIR_W-1:0] pir_gap,
   input wire logic ing_cong,
   input wire logic eg_cong,
   input wire logic [FCM_CRED_INT_W-1:0] credit_bytes
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (rst);
   logic tf_q, uf_q;
   logic [7:0] gap_q;
   wire logic tx_ld = net_tx_valid && tf_q;
   wire logic tx_new = tx_ld && net_tx_word.first;
   wire logic ux_new = usr_tx_valid && usr_tx_word.first && uf_q;
   // gap counts from each new word, so stalls cannot hide a short spacing
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tf_q <= 1'b1;
         uf_q <= 1'b1;
         gap_q <= 8'hFF;
      end else begin
         tf_q <= !net_tx_valid || net_tx_ready;
         uf_q <= !usr_tx_valid || usr_tx_ready;
         gap_q <= tx_ld ? 8'h00 : gap_q + {7'h00, gap_q != 8'hFF};
      end
   end
   AST_PIR_GAP: assert property (tx_ld |-> gap_q >= pir_gap)
      else $error("peak spacing short");
   AST_HOLD: assert property (net_tx_valid && !net_tx_ready |=>
      net_tx_valid && $stable(net_tx_word)) else $error("word not held");
   AST_CAP: assert property (credit_bytes <= credit_max)
      else $error("credit above cap");
   AST_SPEND: assert property (credit_bytes < $past(credit_bytes) |->
      tx_new || $past(tx_new)) else $error("credit spent idle");
   AST_COVER: assert property (tx_new |->
      net_tx_word.len <= $past(credit_bytes)) else $error("frame uncovered");
   AST_ING_F: assert property (tx_new && $past(ing_cong) |->
      net_tx_word.fecn) else $error("net fecn missing");
   AST_EG_B: assert property (tx_new && $past(eg_cong) |->
      net_tx_word.becn) else $error("net becn missing");
   AST_ING_B: assert property (ux_new && $past(ing_cong) |->
      usr_tx_word.becn) else $error("usr becn missing");
   AST_EG_F: assert property (ux_new && $past(eg_cong) |->
      usr_tx_word.fecn) else $error("usr fecn missing");
   cover property (tx_new && net_tx_word.fecn);
   cover property (ux_new && usr_tx_word.fecn);
   cover property (credit_bytes == credit_max);
endmodule
bind fcm_port fcm_port_props u_fcm_port_props (.mclk, .rst, .net_tx_valid,
   .net_tx_word, .net_tx_ready, .usr_tx_valid, .usr_tx_word, .usr_tx_ready,
   .credit_max, .pir_gap, .ing_cong, .eg_cong, .credit_bytes);
`default_nettype wire

//--- tb/fcm_usr.sv
`timescale 1ns/10ps
`default_nettype none
module fcm_usr
   import fcm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   output logic usr_rx_valid,
   output fcm_word_t usr_rx_word,
   input wire logic usr_rx_ready,
   input wire logic usr_tx_valid,
   input wire fcm_word_t usr_tx_word,
   output logic usr_tx_ready,
   input wire logic stall
);
   fcm_word_t got_first;
   logic [15:0] got_cnt;
   assign usr_tx_ready = !stall;
   initial begin
      usr_rx_valid = 1'b0;
      usr_rx_word = '0;
   end
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         got_cnt <= 16'h0000;
         got_first <= '0;
      end else if (usr_tx_valid && usr_tx_ready) begin
         got_cnt <= got_cnt + 16'h0001;
         if (usr_tx_word.first)
            got_first <= usr_tx_word;
      end
   end
   task automatic send(input int n);
      if (got_first.becn)
         repeat (4) @(negedge mclk); // back off when marked
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         usr_rx_valid = 1'b1;
         usr_rx_word = '{i == 0, i == n - 1, 1'b0, 1'b0, n[12:0], i[7:0]};
         while (!usr_rx_ready)
            @(negedge mclk);
         @(posedge mclk);
      end
      @(negedge mclk);
      usr_rx_valid = 1'b0;
      usr_rx_word = ~usr_rx_word;
   endtask
endmodule
`default_nettype wire

//--- tb/fcm_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fcm_port_tb;
   import fcm_pkg::*;
   logic mclk, rst, usr_rx_valid, usr_rx_ready, net_tx_valid, net_tx_ready;
   logic net_rx_valid, net_rx_ready, usr_tx_valid, usr_tx_ready, stall;
   logic ing_cong, eg_cong;
   fcm_word_t usr_rx_word, net_tx_word, net_rx_word, usr_tx_word, tx_first;
   logic [FCM_CRED_W-1:0] cir_inc;
   logic [FCM_CRED_INT_W-1:0] credit_max, credit_bytes;
   logic [FCM_PIR_W-1:0] pir_gap;
   logic [FCM_LVL_W-1:0] ing_thresh, eg_thresh;
   int error_cnt = 0, n_checks = 0, n_tx = 0, cyc = 0, t_last, t0, n0;
   fcm_port u_fcm_port (.mclk, .rst, .usr_rx_valid, .usr_rx_word,
      .usr_rx_ready, .net_tx_valid, .net_tx_word, .net_tx_ready,
      .net_rx_valid, .net_rx_word, .net_rx_ready, .usr_tx_valid,
      .usr_tx_word, .usr_tx_ready, .cir_inc, .credit_max, .pir_gap,
      .ing_thresh, .eg_thresh, .ing_cong, .eg_cong, .credit_bytes);
   fcm_usr u_fcm_usr (.mclk, .rst, .usr_rx_valid, .usr_rx_word,
      .usr_rx_ready, .usr_tx_valid, .usr_tx_word, .usr_tx_ready, .stall);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (net_tx_valid && net_tx_ready) begin
         n_tx <= n_tx + 1;
         t_last <= cyc;
         if (net_tx_word.first)
            tx_first <= net_tx_word;
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic net_send(input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge mclk);
         net_rx_valid = 1'b1;
         net_rx_word = '{i == 0, i == n - 1, 1'b0, 1'b0, n[12:0], 8'hA5};
         while (!net_rx_ready)
            @(negedge mclk);
         @(posedge mclk);
      end
      @(negedge mclk);
      net_rx_valid = 1'b0;
      net_rx_word = ~net_rx_word;
   endtask
   initial begin
      repeat (4000) @(posedge mclk);
      error_cnt++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      net_rx_valid = 1'b0;
      net_rx_word = '0;
      net_tx_ready = 1'b1;
      stall = 1'b0;
      cir_inc = 24'h000080;
      credit_max = 16'h0010;
      pir_gap = 8'h02;
      ing_thresh = 5'h03;
      eg_thresh = 5'h03;
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      repeat (40) @(negedge mclk);
      chk("credit_sat", 16'h0010, credit_bytes);
      chk("ing_cong_idle", 0, ing_cong);
      chk("eg_cong_idle", 0, eg_cong);
      chk("usr_rx_ready", 1, usr_rx_ready);
      chk("net_rx_ready", 1, net_rx_ready);
      // ingress backs up while the network side stalls
      net_tx_ready = 1'b0;
      u_fcm_usr.send(4);
      u_fcm_usr.send(4);
      repeat (4) @(negedge mclk);
      chk("ing_cong", 1, ing_cong);
      net_send(2);
      repeat (8) @(negedge mclk);
      chk("usr_becn", 1, u_fcm_usr.got_first.becn);
      chk("usr_fecn", 0, u_fcm_usr.got_first.fecn);
      net_tx_ready = 1'b1;
      repeat (40) @(negedge mclk);
      chk("net_fecn", 1, tx_first.fecn);
      chk("net_cnt", 8, n_tx);
      chk("ing_cong_clr", 0, ing_cong);
      // egress backs up while the user stalls
      stall = 1'b1;
      net_send(3);
      net_send(3);
      repeat (4) @(negedge mclk);
      chk("eg_cong", 1, eg_cong);
      u_fcm_usr.send(2);
      repeat (20) @(negedge mclk);
      chk("net_becn", 1, tx_first.becn);
      stall = 1'b0;
      repeat (20) @(negedge mclk);
      chk("usr_fecn2", 1, u_fcm_usr.got_first.fecn);
      chk("usr_cnt", 8, u_fcm_usr.got_cnt);
      // burst on saved credit, then held to the committed rate
      pir_gap = 8'h00;
      repeat (40) @(negedge mclk);
      t0 = cyc;
      n0 = n_tx;
      repeat (3) u_fcm_usr.send(16);
      for (int k = 0; k < 400 && n_tx < n0 + 48; k++)
         @(negedge mclk);
      chk("burst_cnt", 48, n_tx - n0);
      chk("cir_time", 1, t_last - t0 >= 64);
      summarize();
   end
endmodule
`default_nettype wire
